// ===== hdl/storage_ref_map.vh
`ifndef STORAGE_REF_MAP_VH
`define STORAGE_REF_MAP_VH
`define OP_JUMP 4'h1
`define OP_MULTIPLY 4'h2
`define OP_DIVIDE 4'h3
`define OP_STORE_EXT 4'h4
`define OP_RETURN_JUMP 4'h5
`define OP_STORE_ACC 4'h6
`define OP_STORE_PARITY 4'h7
`define OP_ADD 4'h8
`define OP_SUB 4'h9
`define OP_AND 4'hA
`define OP_XOR 4'hB
`define OP_LOAD_ACC 4'hC
`define OP_INCR_MEM 4'hD
`define OP_LOAD_EXT 4'hE
`define OP_ADD_EXT 4'hF
`define SUB_HALT 4'h0
`define SUB_INPUT 4'h2
`define INDEX2_ADDR 16'h00FF
`define IO_TIMEOUT_CYCLES 8'h64
`define MAX_INDIRECT 8'h3F
`endif

// ===== hdl/ones_comp_adder.v
`timescale 1ns/1ps
// Sixteen-bit one's complement adder with end-around carry.
module ones_comp_adder (
    input wire [15:0] a,
    input wire [15:0] b,
    output wire [15:0] sum,
    output wire overflow
);
    wire [16:0] raw;
    wire [16:0] wrapped;
    assign raw = {1'b0, a} + {1'b0, b};
    assign wrapped = {1'b0, raw[15:0]} + {16'h0000, raw[16]};
    // Minus zero is kept as the hardware produces it; no normalisation is done.
    assign sum = wrapped[15:0];
    assign overflow = (a[15] == b[15]) && (sum[15] != a[15]);
endmodule // ones_comp_adder

// ===== hdl/storage_ref_exec.v
`timescale 1ns/1ps
`include "storage_ref_map.vh"
// Notes on behaviour
// RULE1: Unconditional jump loads P from the effective address.
// RULE2: Bits 11..8 pick mode; bit 8 adds (00FF), bit 9 adds Q; delta zero skips.
// RULE3: Relative indirect chains through bit 15 only in multilevel mode.
// RULE4: Multiply gives 32-bit one's complement product, high half in Q.
// RULE5: Divide Q:A by operand, quotient to A, remainder to Q.
// RULE6: Divide sets overflow when the quotient does not fit A.
// RULE7: Overflow stays set until a skip-on-overflow clears it.
// RULE8: Store Q at effective address, Q unchanged.
// RULE9: Return jump stores next address at EA and jumps to EA plus one.
// RULE10: Store A at effective address, A unchanged.
// RULE11: Store A, then A becomes 0001 if stored parity bit set else 0000.
// RULE12: Add operand to A with overflow detection.
// RULE13: Subtract operand from A, overflow as for add.
// RULE14: A becomes A AND operand.
// RULE15: A becomes A XOR operand.
// RULE16: Load A from effective address.
// RULE17: Increment memory word by one, A and Q untouched, overflow as add.
// RULE18: Load Q from effective address.
// RULE19: Add operand to Q, overflow as for add.
// RULE20: Upper nibble zero means register reference; sub-opcode 11..8, modifier 7..0.
// RULE21: Sub-opcode 0, zero modifier halts when stop switch on, else no-op.
// RULE22: Input word from device named by Q; reply P+1, external P+1+d, internal P+d.
// RULE23: Index one is Q, index two is word 00FF, added after indirection.
// RULE24: Multilevel mode bit selects chaining; clear means whole indirect word is base.
// RULE25: A device answers with reply or external reject, never both.
// RULE26: No answer within the timeout window gives an internal reject.
module storage_ref_exec (
    input wire sys_clk,
    input wire reset_n,
    input wire run,
    input wire stop_switch,
    input wire multilevel_mode,
    input wire skip_on_overflow,
    output reg mem_req,
    output reg mem_write,
    output reg [15:0] mem_addr,
    output reg [15:0] mem_wdata,
    input wire mem_ack,
    input wire [15:0] mem_rdata,
    input wire mem_rparity,
    output reg io_req,
    output reg [15:0] io_dev,
    input wire io_reply,
    input wire io_reject,
    input wire [15:0] io_rdata,
    output reg [15:0] p_out,
    output reg [15:0] acc_out,
    output reg [15:0] ext_out,
    output reg overflow,
    output reg halted,
    output reg busy
);
    localparam [9:0] ST_FETCH = 10'h001;
    localparam [9:0] ST_DECODE = 10'h002;
    localparam [9:0] ST_WORD2 = 10'h004;
    localparam [9:0] ST_INDIR = 10'h008;
    localparam [9:0] ST_IDX2 = 10'h010;
    localparam [9:0] ST_OPER = 10'h020;
    localparam [9:0] ST_EXEC = 10'h040;
    localparam [9:0] ST_WRITE = 10'h080;
    localparam [9:0] ST_IO = 10'h100;
    localparam [9:0] ST_HALT = 10'h200;
    localparam [7:0] TIMEOUT = `IO_TIMEOUT_CYCLES;

    reg rst_s1, rst_s2;
    reg rep_a, rep_b, rep_c, rej_a, rej_b, rej_c;
    reg [9:0] state;
    reg [15:0] instr, ea, word2, stash;
    reg [7:0] io_cnt;
    reg [7:0] chain_cnt;
    reg mem_phase;
    wire rst_n = rst_s2;

    // Pins from devices are outside this clock; an answer counts while two stages both show it high.
    wire reply_ok = rep_b & rep_c;
    wire reject_ok = rej_b & rej_c;

    wire [3:0] opc = instr[15:12];
    wire [3:0] mode = instr[11:8];
    wire [7:0] delta = instr[7:0];
    wire dzero = (delta == 8'h00);
    wire [15:0] dsext = {{8{delta[7]}}, delta};

    function [15:0] next_seq;
        input [15:0] p;
        input dz;
        begin
            next_seq = dz ? p + 16'h0002 : p + 16'h0001;
        end
    endfunction

    function is_read_op;
        input [3:0] op;
        begin
            is_read_op = (op == `OP_MULTIPLY) || (op == `OP_DIVIDE) || (op >= `OP_ADD &&
                op != `OP_INCR_MEM);
        end
    endfunction

    reg [15:0] add_a, add_b;
    wire [15:0] add_sum;
    wire add_ovf;
    ones_comp_adder u_add (
        .a(add_a),
        .b(add_b),
        .sum(add_sum),
        .overflow(add_ovf)
    );

    // Signed magnitude views for multiply and divide.
    wire [15:0] acc_mag = acc_out[15] ? ~acc_out : acc_out;
    wire [15:0] opd_mag = stash[15] ? ~stash : stash;
    wire [31:0] prod_mag = acc_mag * opd_mag;
    wire prod_neg = acc_out[15] ^ stash[15];
    wire [31:0] prod = prod_neg ? ~prod_mag : prod_mag;
    wire [31:0] dvd_raw = {ext_out, acc_out};
    wire [31:0] dvd_mag = ext_out[15] ? ~dvd_raw : dvd_raw;
    wire [31:0] quot_mag = (opd_mag == 16'h0000) ? 32'hFFFFFFFF : dvd_mag / {16'h0000, opd_mag};
    wire [31:0] rem_mag = (opd_mag == 16'h0000) ? dvd_mag : dvd_mag % {16'h0000, opd_mag};
    wire quot_big = (quot_mag[31:15] != 17'h00000);
    wire [15:0] quot = (ext_out[15] ^ stash[15]) ? ~quot_mag[15:0] : quot_mag[15:0];
    wire [15:0] rem = ext_out[15] ? ~rem_mag[15:0] : rem_mag[15:0];

    always @*
    begin
        add_a = acc_out;
        add_b = stash;
        case (opc)
            `OP_SUB: add_b = ~stash; // RULE13
            `OP_INCR_MEM:
            begin
                add_a = stash;
                add_b = 16'h0001; // RULE17
            end
            `OP_ADD_EXT: add_a = ext_out; // RULE19
            default: add_a = acc_out;
        endcase
    end

    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rep_a <= 1'b0;
            rep_b <= 1'b0;
            rep_c <= 1'b0;
            rej_a <= 1'b0;
            rej_b <= 1'b0;
            rej_c <= 1'b0;
        end
        else
        begin
            rep_a <= io_reply;
            rep_b <= rep_a;
            rep_c <= rep_b;
            rej_a <= io_reject;
            rej_b <= rej_a;
            rej_c <= rej_b;
        end
    end

    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_FETCH;
            instr <= 16'h0000;
            ea <= 16'h0000;
            word2 <= 16'h0000;
            stash <= 16'h0000;
            io_cnt <= 8'h00;
            chain_cnt <= 8'h00;
            mem_phase <= 1'b0;
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            mem_addr <= 16'h0000;
            mem_wdata <= 16'h0000;
            io_req <= 1'b0;
            io_dev <= 16'h0000;
            p_out <= 16'h0000;
            acc_out <= 16'h0000;
            ext_out <= 16'h0000;
            overflow <= 1'b0;
            halted <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            // Clearing is done by the skip_on_overflow input; an overflow in the same cycle wins.
            if (skip_on_overflow)
                overflow <= 1'b0; // RULE7
            case (state)
                ST_FETCH:
                begin
                    busy <= 1'b0;
                    if (run && !mem_phase)
                    begin
                        busy <= 1'b1;
                        mem_req <= 1'b1;
                        mem_write <= 1'b0;
                        mem_addr <= p_out;
                        mem_phase <= 1'b1;
                    end
                    else if (mem_phase && mem_ack)
                    begin
                        mem_req <= 1'b0;
                        mem_phase <= 1'b0;
                        instr <= mem_rdata;
                        state <= ST_DECODE;
                    end
                end
                ST_DECODE:
                begin
                    if (opc == 4'h0)
                    begin
                        if (mode == `SUB_HALT && dzero) // RULE20
                        begin
                            p_out <= p_out + 16'h0001;
                            if (stop_switch)
                            begin
                                halted <= 1'b1; // RULE21
                                state <= ST_HALT;
                            end
                            else
                                state <= ST_FETCH;
                        end
                        else if (mode == `SUB_INPUT)
                        begin
                            io_req <= 1'b1;
                            io_dev <= ext_out; // RULE22
                            io_cnt <= 8'h00;
                            state <= ST_IO;
                        end
                        else
                        begin
                            // Other register instructions are outside this block.
                            p_out <= p_out + 16'h0001;
                            state <= ST_FETCH;
                        end
                    end
                    else if (dzero)
                    begin
                        mem_req <= 1'b1;
                        mem_addr <= p_out + 16'h0001;
                        state <= ST_WORD2;
                    end
                    else
                    begin
                        chain_cnt <= 8'h00;
                        case (mode[3:2]) // RULE2
                            2'b00: ea <= {8'h00, delta};
                            2'b01: ea <= {8'h00, delta};
                            default: ea <= p_out + dsext;
                        endcase
                        if (mode[2])
                        begin
                            mem_addr <= mode[3] ? p_out + dsext : {8'h00, delta};
                            state <= ST_INDIR;
                        end
                        else
                            state <= ST_IDX2;
                    end
                end
                ST_WORD2:
                begin
                    if (mem_ack)
                    begin
                        mem_req <= 1'b0;
                        word2 <= mem_rdata;
                        chain_cnt <= 8'h00;
                        case (mode[3:2])
                            2'b00: ea <= (mode[1:0] == 2'b00) ? p_out + 16'h0001 : mem_rdata;
                            2'b01: ea <= mem_rdata;
                            default: ea <= p_out + 16'h0001 + mem_rdata;
                        endcase
                        if (mode[3:2] == 2'b11)
                        begin
                            mem_addr <= p_out + 16'h0001 + mem_rdata;
                            state <= ST_INDIR;
                        end
                        else
                            state <= ST_IDX2;
                    end
                end
                ST_INDIR:
                begin
                    if (!mem_phase)
                    begin
                        mem_req <= 1'b1;
                        mem_phase <= 1'b1;
                    end
                    else if (mem_ack)
                    begin
                        mem_req <= 1'b0;
                        mem_phase <= 1'b0;
                        ea <= mem_rdata;
                        chain_cnt <= chain_cnt + 8'h01;
                        // The depth cap stops a looping pointer chain from hanging the machine.
                        if (mode[3] && multilevel_mode && mem_rdata[15] &&
                            chain_cnt < `MAX_INDIRECT) // RULE3 RULE24
                            mem_addr <= {1'b0, mem_rdata[14:0]};
                        else
                        begin
                            if (mode[3] && multilevel_mode)
                                ea <= {1'b0, mem_rdata[14:0]};
                            state <= ST_IDX2;
                        end
                    end
                end
                ST_IDX2:
                begin
                    // Q is added first, then word 00FF, after indirection is done.
                    if (!mem_phase)
                    begin
                        if (mode[1])
                            ea <= ea + ext_out + {15'h0000, (ea + ext_out) < ea}; // RULE23
                        if (mode[0])
                        begin
                            mem_req <= 1'b1;
                            mem_addr <= `INDEX2_ADDR;
                            mem_phase <= 1'b1;
                        end
                        else
                            state <= ST_OPER;
                    end
                    else if (mem_ack)
                    begin
                        mem_req <= 1'b0;
                        mem_phase <= 1'b0;
                        ea <= ea + mem_rdata + {15'h0000, (ea + mem_rdata) < ea}; // RULE23
                        state <= ST_OPER;
                    end
                end
                ST_OPER:
                begin
                    if (!mem_phase)
                    begin
                        if (dzero && mode[3:2] == 2'b00 && is_read_op(opc))
                        begin
                            stash <= ea; // Constant mode: the address is the operand.
                            state <= ST_EXEC;
                        end
                        else if (is_read_op(opc) || opc == `OP_INCR_MEM)
                        begin
                            mem_req <= 1'b1;
                            mem_addr <= ea;
                            mem_phase <= 1'b1;
                        end
                        else
                            state <= ST_EXEC;
                    end
                    else if (mem_ack)
                    begin
                        mem_req <= 1'b0;
                        mem_phase <= 1'b0;
                        stash <= mem_rdata;
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC:
                begin
                    p_out <= next_seq(p_out, dzero); // RULE2
                    state <= ST_FETCH;
                    mem_addr <= ea;
                    mem_write <= 1'b1;
                    case (opc)
                        `OP_JUMP:
                        begin
                            p_out <= ea; // RULE1
                            mem_write <= 1'b0;
                        end
                        `OP_MULTIPLY:
                        begin
                            ext_out <= prod[31:16]; // RULE4
                            acc_out <= prod[15:0];
                        end
                        `OP_DIVIDE:
                        begin
                            acc_out <= quot; // RULE5
                            ext_out <= rem;
                            if (quot_big)
                                overflow <= 1'b1; // RULE6
                        end
                        `OP_ADD, `OP_SUB:
                        begin
                            acc_out <= add_sum; // RULE12 RULE13
                            if (add_ovf)
                                overflow <= 1'b1;
                        end
                        `OP_AND: acc_out <= acc_out & stash; // RULE14
                        `OP_XOR: acc_out <= acc_out ^ stash; // RULE15
                        `OP_LOAD_ACC: acc_out <= stash; // RULE16
                        `OP_LOAD_EXT: ext_out <= stash; // RULE18
                        `OP_ADD_EXT:
                        begin
                            ext_out <= add_sum; // RULE19
                            if (add_ovf)
                                overflow <= 1'b1;
                        end
                        default: mem_write <= 1'b0;
                    endcase
                    case (opc)
                        `OP_STORE_EXT, `OP_STORE_ACC, `OP_STORE_PARITY,
                        `OP_RETURN_JUMP, `OP_INCR_MEM:
                        begin
                            mem_req <= 1'b1;
                            mem_write <= 1'b1;
                            state <= ST_WRITE;
                        end
                        default: mem_write <= 1'b0;
                    endcase
                    case (opc)
                        `OP_STORE_EXT: mem_wdata <= ext_out; // RULE8
                        `OP_STORE_ACC, `OP_STORE_PARITY: mem_wdata <= acc_out; // RULE10
                        `OP_RETURN_JUMP: mem_wdata <= next_seq(p_out, dzero); // RULE9
                        `OP_INCR_MEM:
                        begin
                            mem_wdata <= add_sum; // RULE17
                            if (add_ovf)
                                overflow <= 1'b1;
                        end
                        default: mem_wdata <= mem_wdata;
                    endcase
                    if (opc == `OP_RETURN_JUMP)
                        p_out <= ea + 16'h0001; // RULE9
                end
                ST_WRITE:
                begin
                    if (mem_ack)
                    begin
                        mem_req <= 1'b0;
                        mem_write <= 1'b0;
                        if (opc == `OP_STORE_PARITY)
                            acc_out <= {15'h0000, mem_rparity}; // RULE11
                        state <= ST_FETCH;
                    end
                end
                ST_IO:
                begin
                    io_cnt <= io_cnt + 8'h01;
                    if (reply_ok)
                    begin
                        io_req <= 1'b0;
                        acc_out <= io_rdata; // RULE22 RULE25
                        p_out <= p_out + 16'h0001;
                        state <= ST_FETCH;
                    end
                    else if (reject_ok)
                    begin
                        io_req <= 1'b0;
                        p_out <= p_out + 16'h0001 + dsext; // RULE22
                        state <= ST_FETCH;
                    end
                    else if (io_cnt >= TIMEOUT)
                    begin
                        io_req <= 1'b0;
                        p_out <= p_out + dsext; // RULE26
                        state <= ST_FETCH;
                    end
                end
                ST_HALT:
                begin
                    busy <= 1'b0;
                    if (!stop_switch)
                    begin
                        halted <= 1'b0;
                        state <= ST_FETCH;
                    end
                end
                default: state <= ST_FETCH;
            endcase
        end
    end
endmodule // storage_ref_exec

// ===== test/storage_ref_exec_asserts.sv
`timescale 1ns/1ps
module storage_ref_exec_asserts (
    input wire sys_clk,
    input wire reset_n,
    input wire stop_switch,
    input wire skip_on_overflow,
    input wire mem_req,
    input wire mem_write,
    input wire [15:0] mem_addr,
    input wire [15:0] mem_wdata,
    input wire mem_ack,
    input wire io_req,
    input wire [15:0] io_dev,
    input wire [15:0] ext_out,
    input wire overflow,
    input wire halted
);
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!reset_n);
req_hold_a:
    assert property (mem_req && !mem_ack |=> mem_req) else $error("request dropped early");
addr_hold_a:
    assert property (mem_req && !mem_ack |=> $stable(mem_addr)) else $error("address moved");
wdata_hold_a:
    assert property (mem_req && mem_write && !mem_ack |=> mem_write && $stable(mem_wdata))
        else $error("write data moved");
req_gap_a:
    assert property (mem_req && mem_ack |=> !mem_req) else $error("no gap after access");
io_select_a:
    assert property (io_req |-> io_dev == ext_out) else $error("device select not Q");
io_limit_a:
    assert property ($rose(io_req) |-> ##[1:110] !io_req) else $error("input never ended");
ovf_sticky_a:
    assert property (overflow && !skip_on_overflow |=> overflow) else $error("overflow lost");
halt_cause_a:
    assert property ($rose(halted) |-> stop_switch) else $error("halt with switch off");
ext_keep_a:
    assert property (mem_req && mem_write && mem_ack |=> $stable(ext_out) [*2])
        else $error("store changed Q");
endmodule // storage_ref_exec_asserts
bind storage_ref_exec storage_ref_exec_asserts u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
    .stop_switch(stop_switch), .skip_on_overflow(skip_on_overflow), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .io_req(io_req), .io_dev(io_dev), .ext_out(ext_out), .overflow(overflow),
    .halted(halted));

// ===== test/mem_io_model.sv
`timescale 1ns/1ps
module mem_io_model (
    input wire sys_clk,
    input wire [1:0] lat,
    input wire [1:0] io_mode,
    input wire mem_req,
    input wire mem_write,
    input wire [15:0] mem_addr,
    input wire [15:0] mem_wdata,
    output reg mem_ack = 1'b0,
    output reg [15:0] mem_rdata = 16'h0000,
    output reg mem_rparity = 1'b0,
    input wire io_req,
    input wire [15:0] io_dev,
    output reg io_reply = 1'b0,
    output reg io_reject = 1'b0,
    output reg [15:0] io_rdata = 16'h0000
);
parameter [15:0] DEV_SEL = 16'h0042;
parameter [15:0] DEV_WORD = 16'hBEEF;
reg [15:0] words [0:65535];
reg [1:0] wait_cnt = 2'h0;
// Read data toggles outside the ack cycle so a late sample is never lucky.
always @(posedge sys_clk)
begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack)
    begin
        if (wait_cnt != lat)
            wait_cnt <= wait_cnt + 2'h1;
        else
        begin
            wait_cnt <= 2'h0;
            mem_ack <= 1'b1;
            if (mem_write)
            begin
                words[mem_addr] <= mem_wdata;
                mem_rparity <= ^mem_wdata;
            end
            else
                mem_rdata <= words[mem_addr];
        end
    end
end
// Only the selected device answers, and never with both kinds of answer.
always @(posedge sys_clk)
begin
    io_reply <= io_req && io_dev == DEV_SEL && io_mode == 2'h1;
    io_reject <= io_req && io_dev == DEV_SEL && io_mode == 2'h2;
    io_rdata <= (io_req && io_mode == 2'h1) ? DEV_WORD : ~io_rdata;
end
endmodule // mem_io_model

// ===== test/storage_ref_exec_bench.sv
`timescale 1ns/1ps
module storage_ref_exec_bench;
reg sys_clk = 1'b0;
reg reset_n = 1'b0;
reg run = 1'b1;
reg stop_switch = 1'b1;
reg multilevel_mode = 1'b0;
reg skip_on_overflow = 1'b0;
reg [1:0] lat = 2'h0;
reg [1:0] io_mode = 2'h0;
wire mem_req, mem_write, mem_ack, mem_rparity, io_req, io_reply, io_reject, overflow, halted, busy;
wire [15:0] mem_addr, mem_wdata, mem_rdata, io_dev, io_rdata, p_out, acc_out, ext_out;
integer num_errors = 0;
integer tests_run = 0;
integer cycles = 0;
integer k, j;
always #10 sys_clk = ~sys_clk;
storage_ref_exec DUT (.sys_clk(sys_clk), .reset_n(reset_n), .run(run),
    .stop_switch(stop_switch), .multilevel_mode(multilevel_mode),
    .skip_on_overflow(skip_on_overflow), .mem_req(mem_req), .mem_write(mem_write),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .mem_rparity(mem_rparity), .io_req(io_req), .io_dev(io_dev), .io_reply(io_reply),
    .io_reject(io_reject), .io_rdata(io_rdata), .p_out(p_out), .acc_out(acc_out),
    .ext_out(ext_out), .overflow(overflow), .halted(halted), .busy(busy));
mem_io_model m (.sys_clk(sys_clk), .lat(lat), .io_mode(io_mode), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .mem_rparity(mem_rparity), .io_req(io_req), .io_dev(io_dev),
    .io_reply(io_reply), .io_reject(io_reject), .io_rdata(io_rdata));
task final_report;
begin
    $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
end
endtask
always @(posedge sys_clk)
begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
        num_errors = num_errors + 1;
        final_report;
    end
end
task check(input [15:0] exp, input [15:0] got);
begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
        num_errors = num_errors + 1;
        $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
end
endtask
task put(input [15:0] a, input [15:0] d);
    m.words[a] = d;
endtask
task prep;
begin
    @(negedge sys_clk);
    reset_n = 1'b0;
    for (k = 0; k < 65536; k = k + 1)
        m.words[k] = 16'h0000;
end
endtask
task go;
    integer n;
begin
    repeat (3) @(negedge sys_clk);
    reset_n = 1'b1;
    n = 0;
    while (halted !== 1'b1 && n < 2000)
    begin
        @(negedge sys_clk);
        n = n + 1;
    end
    check(16'h0001, {15'h0000, halted});
end
endtask
task t_jump;
begin
    prep;
    lat = 2'h3;
    put(16'h0000, 16'h1005);
    put(16'h0001, 16'hC010);
    put(16'h0005, 16'h5030);
    put(16'h0031, 16'hC011);
    put(16'h0010, 16'hAAAA);
    put(16'h0011, 16'h1234);
    go;
    lat = 2'h0;
    check(16'h1234, acc_out);
    check(16'h0006, m.words[16'h0030]);
    $display("jump test done");
end
endtask
task t_alu;
begin
    prep;
    put(16'h0000, 16'hC010);
    put(16'h0001, 16'h2011);
    put(16'h0002, 16'h3019);
    put(16'h0003, 16'h4013);
    put(16'h0004, 16'hE014);
    put(16'h0005, 16'hF015);
    put(16'h0006, 16'hB016);
    put(16'h0007, 16'hA017);
    put(16'h0008, 16'h9018);
    put(16'h0009, 16'hD012);
    put(16'h0010, 16'h0003);
    put(16'h0011, 16'h0005);
    put(16'h0012, 16'h0010);
    put(16'h0013, 16'hFFFF);
    put(16'h0014, 16'h0100);
    put(16'h0015, 16'h0020);
    put(16'h0016, 16'h00FF);
    put(16'h0017, 16'h0F30);
    put(16'h0018, 16'h0010);
    put(16'h0019, 16'h0004);
    go;
    check(16'h0020, acc_out);
    check(16'h0120, ext_out);
    check(16'h0003, m.words[16'h0013]);
    check(16'h0011, m.words[16'h0012]);
    check(16'h0000, {15'h0000, overflow});
    $display("arithmetic test done");
end
endtask
task t_ovf;
begin
    prep;
    put(16'h0000, 16'hC010);
    put(16'h0001, 16'h8011);
    put(16'h0002, 16'hC012);
    put(16'h0010, 16'h7FFF);
    put(16'h0011, 16'h0001);
    put(16'h0012, 16'h0005);
    go;
    check(16'h0001, {15'h0000, overflow});
    skip_on_overflow = 1'b1;
    @(negedge sys_clk);
    skip_on_overflow = 1'b0;
    @(negedge sys_clk);
    check(16'h0000, {15'h0000, overflow});
    stop_switch = 1'b0;
    repeat (12) @(negedge sys_clk);
    check(16'h0000, {15'h0000, halted});
    stop_switch = 1'b1;
    $display("overflow test done");
end
endtask
task t_parity;
begin
    for (j = 1; j < 4; j = j + 2)
    begin
        prep;
        put(16'h0000, 16'hC011);
        put(16'h0001, 16'h7010);
        put(16'h0011, j[15:0]);
        go;
        check(j[15:0], m.words[16'h0010]);
        check({15'h0000, ^j[15:0]}, acc_out);
    end
    $display("parity test done");
end
endtask
task t_indirect;
begin
    for (j = 0; j < 2; j = j + 1)
    begin
        prep;
        multilevel_mode = j[0];
        put(16'h0000, 16'hCD04);
        put(16'h0004, 16'h8006);
        put(16'h0006, 16'h0008);
        put(16'h8006, 16'h0008);
        put(16'h0009, 16'h5555);
        put(16'h8007, 16'h0008);
        put(16'h00FF, 16'h0001);
        go;
        check(j ? 16'h5555 : 16'h0008, acc_out);
    end
    multilevel_mode = 1'b0;
    $display("indirect test done");
end
endtask
task t_input;
begin
    for (j = 0; j < 3; j = j + 1)
    begin
        prep;
        io_mode = j[1:0];
        put(16'h0000, 16'hE010);
        put(16'h0001, 16'h0203);
        put(16'h0002, 16'hB013);
        put(16'h0004, 16'hC011);
        put(16'h0010, 16'h0042);
        put(16'h0011, 16'h1111);
        put(16'h0013, 16'h00F0);
        go;
        check(j == 1 ? 16'hBE1F : (j == 2 ? 16'h0000 : 16'h1111), acc_out);
    end
    io_mode = 2'h0;
    $display("input test done");
end
endtask
initial
begin
    t_jump;
    t_alu;
    t_ovf;
    t_parity;
    t_indirect;
    t_input;
    final_report;
end
endmodule // storage_ref_exec_bench
